/* i2c_mem_pkg.sv */
package i2c_mem_pkg;
    localparam int MEM_AW = 14;
    localparam int MEM_WORDS = 16384;
    // Device type code: value is arbitrary
    localparam logic [3:0] DEV_TYPE = 4'h6;
    localparam logic [3:0] BIT_FIRST = 4'h1;
    localparam logic [3:0] BIT_LAST = 4'h7;
    localparam logic [3:0] BIT_ACK = 4'h8;
    localparam logic [3:0] RECOVER_CLOCKS = 4'h9;
    localparam logic [13:0] ADDR_RESET = 14'h0000;
    localparam int CLK_SYS_NS = 100;
    localparam int SCL_PERIOD_NS = 2500;
    localparam int QUARTER_CYC_I = (SCL_PERIOD_NS / 4 + CLK_SYS_NS - 1) / CLK_SYS_NS;
    localparam logic [3:0] QUARTER_CYC = QUARTER_CYC_I[3:0];

    typedef enum logic [1:0] {
        OP_WRITE = 2'h0,
        OP_READ_CUR = 2'h1,
        OP_READ_RND = 2'h2,
        OP_RECOVER = 2'h3
    } op_t;

    typedef enum logic [2:0] {
        D_IDLE = 3'h0,
        D_DEVADDR = 3'h1,
        D_ADDR_HI = 3'h3,
        D_ADDR_LO = 3'h2,
        D_WDATA = 3'h6,
        D_RDATA = 3'h7
    } dev_state_t;

    typedef enum logic [2:0] {
        H_IDLE = 3'h0,
        H_START = 3'h1,
        H_BIT = 3'h3,
        H_LOADW = 3'h2,
        H_STOP = 3'h6,
        H_RCLK = 3'h7
    } host_state_t;

    typedef enum logic [2:0] {
        PH_DEVW = 3'h0,
        PH_AHI = 3'h1,
        PH_ALO = 3'h3,
        PH_WDATA = 3'h2,
        PH_DEVR = 3'h6,
        PH_RDATA = 3'h7,
        PH_RECOV = 3'h5
    } phase_t;
endpackage

/* i2c_link_if.sv */
`timescale 1ns/1ps
interface i2c_link_if;
    logic scl;
    logic host_sda_o;
    logic host_sda_oe;
    logic dev_sda_o;
    logic dev_sda_oe;
    logic sda;

    // Open-drain wire with pull-up: an enabled low driver wins
    assign sda = ~((host_sda_oe & ~host_sda_o) | (dev_sda_oe & ~dev_sda_o));

    modport host (output scl, output host_sda_o, output host_sda_oe, input sda);
    modport dev (input scl, input sda, output dev_sda_o, output dev_sda_oe);
endinterface // i2c_link_if

/* i2c_mem_device.sv */
`timescale 1ns/1ps
module i2c_mem_device (
    // System side
    input wire logic clk_sys,
    input wire logic rst_n,
    // Straps
    input wire logic addr_select_bit2,
    input wire logic addr_select_bit1,
    input wire logic addr_select_bit0,
    input wire logic wp,
    // Status on the system clock
    output logic bus_active,
    output logic byte_written,
    // Link
    i2c_link_if.dev lnk
);
    logic start_tog;
    logic start_mark;
    logic stop_tog;
    logic start_seen;
    logic [3:0] pin_meta;
    logic [3:0] pin_s;
    i2c_mem_pkg::dev_state_t state;
    logic [3:0] cnt;
    logic [7:0] shreg;
    logic [7:0] txbyte;
    logic [5:0] addr_hi;
    logic [13:0] addr;
    logic drive_next;
    logic sda_oe_q;
    logic wr_tog;
    logic [1:0] act_sync;
    logic [2:0] wr_sync;
    logic [7:0] mem [i2c_mem_pkg::MEM_WORDS];

    // Start and stop are the only events seen while SCL is high, so the
    // data line itself clocks them; the frame level ends with the stop.
    always_ff @(negedge lnk.sda or negedge rst_n) begin
        if (!rst_n) begin
            start_tog <= 1'b0;
            start_mark <= 1'b1;
        end else if (lnk.scl) begin
            start_tog <= ~start_tog;
            start_mark <= stop_tog;
        end
    end

    always_ff @(posedge lnk.sda or negedge rst_n) begin
        if (!rst_n) begin
            stop_tog <= 1'b0;
        end else if (lnk.scl) begin
            stop_tog <= ~stop_tog;
        end
    end

    wire in_frame = (start_mark == stop_tog);
    wire new_frame = (start_tog != start_seen);
    wire [7:0] byte_in = {shreg[6:0], lnk.sda};
    wire type_ok = (byte_in[7:4] == i2c_mem_pkg::DEV_TYPE);
    wire addr_match = type_ok && (byte_in[3:1] == pin_s[2:0]);
    wire wp_s = pin_s[3];
    wire [7:0] rd_word = mem[addr];
    wire ack_clock = (cnt == i2c_mem_pkg::BIT_ACK);
    wire last_bit = (cnt == i2c_mem_pkg::BIT_LAST);
    // Stop before the ack clock never reaches this term
    wire commit = (state == i2c_mem_pkg::D_WDATA) && ack_clock && in_frame;
    wire mem_we = commit && !wp_s;

    // Straps only move between frames; outside frames SCL moves only for recovery clocks,
    // so they settle during the first bits of the address word.
    always_ff @(posedge lnk.scl or negedge rst_n) begin
        if (!rst_n) begin
            pin_meta <= 4'h0;
            pin_s <= 4'h0;
        end else begin
            pin_meta <= {wp, addr_select_bit2, addr_select_bit1, addr_select_bit0};
            pin_s <= pin_meta;
        end
    end

    always_ff @(posedge lnk.scl) begin
        if (mem_we) begin
            mem[addr] <= shreg;
        end
    end

    always_ff @(posedge lnk.scl or negedge rst_n) begin
        if (!rst_n) begin
            start_seen <= 1'b0;
            state <= i2c_mem_pkg::D_IDLE;
            cnt <= 4'h0;
            shreg <= 8'h00;
            txbyte <= 8'h00;
            addr_hi <= 6'h00;
            addr <= i2c_mem_pkg::ADDR_RESET;
            drive_next <= 1'b0;
            wr_tog <= 1'b0;
        end else if (new_frame) begin
            start_seen <= start_tog;
            state <= i2c_mem_pkg::D_DEVADDR;
            shreg <= {7'h00, lnk.sda};
            cnt <= i2c_mem_pkg::BIT_FIRST;
            drive_next <= 1'b0;
        end else if (!in_frame) begin
            state <= i2c_mem_pkg::D_IDLE;
            drive_next <= 1'b0;
        end else begin
            case (state)
                i2c_mem_pkg::D_IDLE: begin
                    drive_next <= 1'b0;
                end
                i2c_mem_pkg::D_RDATA: begin
                    if (ack_clock) begin
                        if (!lnk.sda) begin
                            txbyte <= rd_word;
                            drive_next <= ~rd_word[7];
                            addr <= addr + 14'h0001;
                            cnt <= 4'h0;
                        end else begin
                            state <= i2c_mem_pkg::D_IDLE;
                            drive_next <= 1'b0;
                        end
                    end else if (last_bit) begin
                        drive_next <= 1'b0;
                        cnt <= i2c_mem_pkg::BIT_ACK;
                    end else begin
                        drive_next <= ~txbyte[6];
                        txbyte <= {txbyte[6:0], 1'b0};
                        cnt <= cnt + 4'h1;
                    end
                end
                default: begin
                    if (ack_clock) begin
                        cnt <= 4'h0;
                        drive_next <= 1'b0;
                        case (state)
                            i2c_mem_pkg::D_DEVADDR: begin
                                if (shreg[0]) begin
                                    // Current and random read both start at the held address
                                    state <= i2c_mem_pkg::D_RDATA;
                                    txbyte <= rd_word;
                                    drive_next <= ~rd_word[7];
                                    addr <= addr + 14'h0001;
                                end else begin
                                    state <= i2c_mem_pkg::D_ADDR_HI;
                                end
                            end
                            i2c_mem_pkg::D_ADDR_HI: begin
                                // Upper two bits are ignored
                                addr_hi <= shreg[5:0];
                                state <= i2c_mem_pkg::D_ADDR_LO;
                            end
                            i2c_mem_pkg::D_ADDR_LO: begin
                                addr <= {addr_hi, shreg};
                                state <= i2c_mem_pkg::D_WDATA;
                            end
                            default: begin
                                // Fourteen bit counter wraps to zero by itself
                                addr <= addr + 14'h0001;
                                wr_tog <= wr_tog ^ mem_we;
                            end
                        endcase
                    end else if (last_bit) begin
                        shreg <= byte_in;
                        cnt <= i2c_mem_pkg::BIT_ACK;
                        if (state == i2c_mem_pkg::D_DEVADDR && !addr_match) begin
                            state <= i2c_mem_pkg::D_IDLE;
                        end else begin
                            drive_next <= 1'b1;
                        end
                    end else begin
                        shreg <= byte_in;
                        cnt <= cnt + 4'h1;
                    end
                end
            endcase
        end
    end

    // Output changes on the falling edge so data is stable while SCL is high
    always_ff @(negedge lnk.scl or negedge rst_n) begin
        if (!rst_n) begin
            sda_oe_q <= 1'b0;
        end else begin
            sda_oe_q <= drive_next;
        end
    end

    // A stop releases the line at once, even with SCL parked high
    assign lnk.dev_sda_oe = sda_oe_q & in_frame;
    assign lnk.dev_sda_o = 1'b0;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            act_sync <= 2'h0;
            wr_sync <= 3'h0;
        end else begin
            act_sync <= {act_sync[0], in_frame};
            wr_sync <= {wr_sync[1:0], wr_tog};
        end
    end

    assign bus_active = act_sync[1];
    assign byte_written = wr_sync[2] ^ wr_sync[1];
endmodule // i2c_mem_device

/* i2c_mem_host.sv */
`timescale 1ns/1ps
module i2c_mem_host (
    // System side
    input wire logic clk_sys,
    input wire logic rst_n,
    // Command
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire logic [1:0] cmd_op,
    input wire logic [2:0] cmd_dev,
    input wire logic [13:0] cmd_addr,
    input wire logic [7:0] cmd_len,
    output logic done,
    output logic nack_err,
    // Write data
    input wire logic wr_valid,
    output logic wr_ready,
    input wire logic [7:0] wr_data,
    // Read data
    output logic rd_valid,
    output logic [7:0] rd_data,
    // Link
    i2c_link_if.host lnk
);
    i2c_mem_pkg::host_state_t state;
    i2c_mem_pkg::phase_t phase;
    i2c_mem_pkg::op_t op;
    logic [2:0] dev;
    logic [13:0] addr;
    logic [7:0] len_left;
    logic [7:0] shreg;
    logic [3:0] bitn;
    logic [3:0] tmr;
    logic [1:0] q;
    logic [3:0] rcnt;
    logic rbit;
    logic scl_q;
    logic sda_oe_q;
    logic sda_meta;
    logic sda_s;

    wire tick = (tmr == 4'h0);
    wire rx_mode = (phase == i2c_mem_pkg::PH_RDATA);
    wire ack_slot = (bitn == i2c_mem_pkg::BIT_ACK);
    wire more = (len_left != 8'h00);
    // Ack low while more bytes are wanted, nack on the last
    wire bit_oe = ack_slot ? (rx_mode && more) : (!rx_mode && !shreg[7]);
    wire [7:0] dev_word = {i2c_mem_pkg::DEV_TYPE, dev, phase == i2c_mem_pkg::PH_DEVR};
    wire timed = (state != i2c_mem_pkg::H_IDLE) && (state != i2c_mem_pkg::H_LOADW);
    wire bus_free = sda_s || (rcnt == i2c_mem_pkg::RECOVER_CLOCKS);

    assign cmd_ready = (state == i2c_mem_pkg::H_IDLE);
    assign wr_ready = (state == i2c_mem_pkg::H_LOADW);
    assign lnk.scl = scl_q;
    // Open drain: the line is pulled low or released, never driven high
    assign lnk.host_sda_o = 1'b0;
    assign lnk.host_sda_oe = sda_oe_q;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            sda_meta <= 1'b1;
            sda_s <= 1'b1;
        end else begin
            sda_meta <= lnk.sda;
            sda_s <= sda_meta;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state <= i2c_mem_pkg::H_IDLE;
            phase <= i2c_mem_pkg::PH_DEVW;
            op <= i2c_mem_pkg::OP_WRITE;
            dev <= 3'h0;
            addr <= 14'h0000;
            len_left <= 8'h00;
            shreg <= 8'h00;
            bitn <= 4'h0;
            tmr <= 4'h0;
            q <= 2'h0;
            rcnt <= 4'h0;
            rbit <= 1'b1;
            scl_q <= 1'b1;
            sda_oe_q <= 1'b0;
            done <= 1'b0;
            nack_err <= 1'b0;
            rd_valid <= 1'b0;
            rd_data <= 8'h00;
        end else begin
            done <= 1'b0;
            rd_valid <= 1'b0;
            if (timed) begin
                tmr <= tick ? i2c_mem_pkg::QUARTER_CYC - 4'h1 : tmr - 4'h1;
            end
            if (timed && tick) begin
                q <= q + 2'h1;
            end
            case (state)
                i2c_mem_pkg::H_IDLE: begin
                    if (cmd_valid) begin
                        op <= i2c_mem_pkg::op_t'(cmd_op);
                        dev <= cmd_dev;
                        addr <= cmd_addr;
                        len_left <= cmd_len;
                        nack_err <= 1'b0;
                        rcnt <= 4'h0;
                        q <= 2'h0;
                        tmr <= i2c_mem_pkg::QUARTER_CYC - 4'h1;
                        if (cmd_op == i2c_mem_pkg::OP_RECOVER) begin
                            phase <= i2c_mem_pkg::PH_RECOV;
                            state <= i2c_mem_pkg::H_RCLK;
                        end else begin
                            phase <= (cmd_op == i2c_mem_pkg::OP_READ_CUR) ?
                                i2c_mem_pkg::PH_DEVR : i2c_mem_pkg::PH_DEVW;
                            state <= i2c_mem_pkg::H_START;
                        end
                    end
                end
                i2c_mem_pkg::H_START: begin
                    if (tick) begin
                        case (q)
                            2'h0: sda_oe_q <= 1'b0;
                            2'h1: scl_q <= 1'b1;
                            2'h2: sda_oe_q <= 1'b1;
                            default: begin
                                scl_q <= 1'b0;
                                shreg <= dev_word;
                                bitn <= 4'h0;
                                state <= (phase == i2c_mem_pkg::PH_RECOV) ?
                                    i2c_mem_pkg::H_STOP : i2c_mem_pkg::H_BIT;
                            end
                        endcase
                    end
                end
                i2c_mem_pkg::H_BIT: begin
                    if (tick) begin
                        case (q)
                            2'h0: sda_oe_q <= bit_oe;
                            2'h1: scl_q <= 1'b1;
                            2'h2: rbit <= sda_s;
                            default: begin
                                scl_q <= 1'b0;
                                bitn <= bitn + 4'h1;
                                if (!ack_slot) begin
                                    shreg <= {shreg[6:0], rbit};
                                end else begin
                                    bitn <= 4'h0;
                                    if (rx_mode) begin
                                        rd_data <= shreg;
                                        rd_valid <= 1'b1;
                                        if (more) begin
                                            len_left <= len_left - 8'h01;
                                        end else begin
                                            state <= i2c_mem_pkg::H_STOP;
                                        end
                                    end else if (rbit) begin
                                        // Failed command: software may simply retry it
                                        nack_err <= 1'b1;
                                        state <= i2c_mem_pkg::H_STOP;
                                    end else begin
                                        case (phase)
                                            i2c_mem_pkg::PH_DEVW: begin
                                                phase <= i2c_mem_pkg::PH_AHI;
                                                shreg <= {2'b00, addr[13:8]};
                                            end
                                            i2c_mem_pkg::PH_AHI: begin
                                                phase <= i2c_mem_pkg::PH_ALO;
                                                shreg <= addr[7:0];
                                            end
                                            i2c_mem_pkg::PH_ALO: begin
                                                if (op == i2c_mem_pkg::OP_WRITE) begin
                                                    phase <= i2c_mem_pkg::PH_WDATA;
                                                    state <= i2c_mem_pkg::H_LOADW;
                                                end else begin
                                                    phase <= i2c_mem_pkg::PH_DEVR;
                                                    state <= i2c_mem_pkg::H_START;
                                                end
                                            end
                                            i2c_mem_pkg::PH_WDATA: begin
                                                if (more) begin
                                                    len_left <= len_left - 8'h01;
                                                    state <= i2c_mem_pkg::H_LOADW;
                                                end else begin
                                                    state <= i2c_mem_pkg::H_STOP;
                                                end
                                            end
                                            default: phase <= i2c_mem_pkg::PH_RDATA;
                                        endcase
                                    end
                                end
                            end
                        endcase
                    end
                end
                i2c_mem_pkg::H_LOADW: begin
                    // SCL is held low until data arrives; the device has no timeout
                    if (wr_valid) begin
                        shreg <= wr_data;
                        bitn <= 4'h0;
                        q <= 2'h0;
                        tmr <= i2c_mem_pkg::QUARTER_CYC - 4'h1;
                        state <= i2c_mem_pkg::H_BIT;
                    end
                end
                i2c_mem_pkg::H_STOP: begin
                    if (tick) begin
                        case (q)
                            2'h0: sda_oe_q <= 1'b1;
                            2'h1: scl_q <= 1'b1;
                            2'h2: sda_oe_q <= 1'b0;
                            default: begin
                                done <= 1'b1;
                                state <= i2c_mem_pkg::H_IDLE;
                            end
                        endcase
                    end
                end
                i2c_mem_pkg::H_RCLK: begin
                    if (tick) begin
                        case (q)
                            2'h0: begin
                                sda_oe_q <= 1'b0;
                                if (bus_free) begin
                                    q <= 2'h0;
                                    state <= i2c_mem_pkg::H_START;
                                end
                            end
                            2'h1: scl_q <= 1'b1;
                            2'h2: rcnt <= rcnt + 4'h1;
                            default: scl_q <= 1'b0;
                        endcase
                    end
                end
                default: state <= i2c_mem_pkg::H_IDLE;
            endcase
        end
    end
endmodule // i2c_mem_host

/* i2c_link_asserts.sv */
`timescale 1ns/1ps
module i2c_link_asserts (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Link wires
    input wire logic scl,
    input wire logic host_sda_o,
    input wire logic host_sda_oe,
    input wire logic dev_sda_o,
    input wire logic dev_sda_oe,
    input wire logic sda,
    // Device straps
    input wire logic addr_select_bit2,
    input wire logic addr_select_bit1,
    input wire logic addr_select_bit0
);
    logic scl_q, sda_q, rw;
    logic [3:0] nbit;
    logic [1:0] nbyte;
    logic [7:0] shreg;
    // Start and stop both restart the bit count, so recovery clocks ahead of the start never shift the next frame's count
    wire frame_edge = scl & scl_q & (sda_q != sda);
    wire rise = scl & ~scl_q;
    wire [1:0] next_nbyte = (nbyte == 2'h3) ? 2'h3 : nbyte + 2'h1;
    wire [6:0] own_id = {i2c_mem_pkg::DEV_TYPE, addr_select_bit2, addr_select_bit1, addr_select_bit0};
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            {scl_q, sda_q, rw, nbit, nbyte, shreg} <= {2'b11, 15'h0};
        end else begin
            {scl_q, sda_q} <= {scl, sda};
            if (frame_edge) begin
                {nbit, nbyte} <= 6'h0;
            end else if (rise && nbit == 4'h8) begin
                nbit <= 4'h0;
                nbyte <= next_nbyte;
                rw <= (nbyte == 2'h0) ? shreg[0] : rw;
            end else if (rise) begin
                nbit <= nbit + 4'h1;
                shreg <= {shreg[6:0], sda};
            end
        end
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    sequence s_addr_ack;
        rise && nbit == 4'h8 && nbyte == 2'h0;
    endsequence
    chk_addr_match: assert property (s_addr_ack |-> dev_sda_oe == (shreg[7:1] == own_id))
        else $error("address acknowledge wrong");
    chk_addr_quiet: assert property (rise && nbyte == 2'h0 && nbit != 4'h8 |-> !dev_sda_oe)
        else $error("device drives during address word");
    chk_write_ack: assert property (rise && nbit == 4'h8 && nbyte != 2'h0 && !rw |-> dev_sda_oe)
        else $error("write byte not acknowledged");
    chk_read_ack_free: assert property (rise && nbit == 4'h8 && nbyte != 2'h0 && rw |-> !dev_sda_oe)
        else $error("device holds line on read acknowledge");
    chk_read_drive: assert property (rise && rw && nbyte != 2'h0 && nbit != 4'h0 && nbit != 4'h8
        |-> !host_sda_oe)
        else $error("host drives during read data");
    chk_one_driver: assert property (rise |-> !(host_sda_oe && dev_sda_oe))
        else $error("both ends drive at clock rise");
    chk_hold_high: assert property (scl && $past(scl) |-> $stable(dev_sda_oe))
        else $error("device changes data while clock high");
    chk_open_drain: assert property (host_sda_oe |-> !host_sda_o)
        else $error("host drives data line high");
endmodule // i2c_link_asserts

/* i2c_command_engine_tb_top.sv */
`timescale 1ns/1ps
module i2c_command_engine_tb_top;
    logic clk_sys = 1'b0, rst_n = 1'b0, cmd_valid = 1'b0, wr_valid = 1'b0, wp = 1'b0;
    logic [1:0] cmd_op = 2'h0;
    logic [2:0] cmd_dev = 3'h0, sel = 3'h0;
    logic [13:0] cmd_addr = 14'h0;
    logic [7:0] cmd_len = 8'h0, rd_data;
    logic [7:0] wbuf [0:7];
    logic [7:0] mem [int];
    logic [7:0] rq [$];
    logic cmd_ready, done, nack_err, wr_ready, rd_valid, bus_active, byte_written;
    int n_mismatch = 0, n_checks = 0, wi = 0, bw_n = 0, cyc = 0, i;
    wire [7:0] wr_data = wbuf[wi[2:0]];
    i2c_link_if lnk ();
    i2c_mem_host i2c_mem_host_inst (.clk_sys, .rst_n, .cmd_valid, .cmd_ready, .cmd_op, .cmd_dev,
        .cmd_addr, .cmd_len, .done, .nack_err, .wr_valid, .wr_ready, .wr_data, .rd_valid,
        .rd_data, .lnk(lnk));
    i2c_mem_device i2c_mem_device_inst (.clk_sys, .rst_n, .addr_select_bit2(sel[2]),
        .addr_select_bit1(sel[1]), .addr_select_bit0(sel[0]), .wp, .bus_active,
        .byte_written, .lnk(lnk));
    i2c_link_asserts i2c_link_asserts_inst (.clk_sys, .rst_n, .scl(lnk.scl),
        .host_sda_o(lnk.host_sda_o), .host_sda_oe(lnk.host_sda_oe), .dev_sda_o(lnk.dev_sda_o),
        .dev_sda_oe(lnk.dev_sda_oe), .sda(lnk.sda), .addr_select_bit2(sel[2]),
        .addr_select_bit1(sel[1]), .addr_select_bit0(sel[0]));
    initial forever #50 clk_sys = ~clk_sys;
    task automatic wrap_up();
        if (n_mismatch == 0 && n_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // Strobes move on the edge by non-blocking assignment so the host samples them cleanly
    task automatic run(input logic [1:0] op, input logic [13:0] a, input int n, input logic [2:0] dv);
        @(posedge clk_sys);
        {cmd_op, cmd_addr, cmd_dev, cmd_len} <= {op, a, dv, 8'(n - 1)};
        cmd_valid <= 1'b1;
        wr_valid <= (op == i2c_mem_pkg::OP_WRITE);
        rq.delete();
        @(posedge clk_sys);
        cmd_valid <= 1'b0;
        repeat (9000) begin
            @(posedge clk_sys);
            if (done === 1'b1) break;
        end
        // A command that never finishes counts against the run
        if (done !== 1'b1) n_mismatch++;
        chk("cmd_ready", {7'h0, cmd_ready}, 8'h01);
        wr_valid <= 1'b0;
    endtask
    task automatic rdchk(input int a, input int n);
        chk("rd_count", 8'(rq.size()), 8'(n));
        for (int k = 0; k < n; k++) chk("rd_data", rq[k], mem[(a + k) % 16384]);
    endtask
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        // The write index restarts when the host takes a command
        if (cmd_valid && cmd_ready === 1'b1) wi <= 0;
        else if (wr_valid && wr_ready === 1'b1) wi <= wi + 1;
        if (rd_valid === 1'b1) rq.push_back(rd_data);
        if (byte_written === 1'b1) bw_n <= bw_n + 1;
        if (cyc == 60000) begin
            n_mismatch++;
            wrap_up();
        end
    end
    initial begin
        void'($urandom(6));
        sel = 3'($urandom());
        for (i = 0; i < 8; i++) wbuf[i] = 8'($urandom());
        repeat (5) @(posedge clk_sys);
        rst_n <= 1'b1;
        run(i2c_mem_pkg::OP_WRITE, 14'h3ffe, 5, sel);
        for (i = 0; i < 5; i++) mem[(16382 + i) % 16384] = wbuf[i];
        chk("byte_written", 8'(bw_n), 8'h05);
        chk("bus_active", {7'h0, bus_active}, 8'h00);
        run(i2c_mem_pkg::OP_READ_RND, 14'h3ffe, 4, sel);
        rdchk(16382, 4);
        run(i2c_mem_pkg::OP_READ_CUR, 14'h0, 1, sel);
        rdchk(2, 1);
        run(i2c_mem_pkg::OP_WRITE, 14'h3fff, 1, sel);
        mem[16383] = wbuf[0];
        run(i2c_mem_pkg::OP_READ_CUR, 14'h0, 1, sel);
        rdchk(0, 1);
        wp <= 1'b1;
        wbuf[0] = ~mem[1];
        run(i2c_mem_pkg::OP_WRITE, 14'h0001, 1, sel);
        wp <= 1'b0;
        chk("byte_written", 8'(bw_n), 8'h06);
        run(i2c_mem_pkg::OP_READ_RND, 14'h0001, 1, sel);
        rdchk(1, 1);
        run(i2c_mem_pkg::OP_WRITE, 14'h0, 1, sel ^ 3'h1);
        chk("nack_err", {7'h0, nack_err}, 8'h01);
        run(i2c_mem_pkg::OP_RECOVER, 14'h0, 1, sel);
        chk("nack_err", {7'h0, nack_err}, 8'h00);
        wrap_up();
    end
endmodule // i2c_command_engine_tb_top
